// file: common/gauge_misc_cfg.svh
// Constants for the gauge miscellaneous configuration register.
// Assumes inclusion by bare name from the configuration register design file.
`ifndef GAUGE_MISC_CFG_SVH
`define GAUGE_MISC_CFG_SVH
`define MISC_CFG_ADDR 8'h2b
`define RATE_LIMIT_HI 15
`define RATE_LIMIT_LO 12
`define INSERT_RESET_BIT 11
`define REINIT_BIT 10
`define MIX_HI 9
`define MIX_LO 5
`define AUTO_REVERT_BIT 4
`define PULLUP_LOW_BIT 3
`define EXT_VOLT_BIT 2
`define ALERT_SRC_HI 1
`define ALERT_SRC_LO 0
`define RATE_LIMIT_RESET 4'h3
`define RATE_STEP_PCT_HR 8
`define MIX_RESET 5'h03
`define MISC_CFG_RESET 16'h3860
`define LEARN_STAGE_REVERT 3'h7
`endif

// file: common/gauge_misc_pkg.sv
// Types shared by the gauge configuration register and its field decoder.
// Assumes nothing beyond the constants header.
package gauge_misc_pkg;
	typedef enum logic [1:0] {
		alert_reported = 2'h0,
		alert_average = 2'h1,
		alert_mixed = 2'h2,
		alert_voltage = 2'h3
	} alert_src_e;
	typedef enum logic [3:0] {
		mix_off = 4'h1,
		mix_servo = 4'h2,
		mix_tc = 4'h4,
		mix_idle = 4'h8
	} mix_mode_e;
endpackage : gauge_misc_pkg

// file: hw/gauge_alert_mux.sv
// Selects the charge value that feeds the charge alerts.
// Assumes charge values arrive registered in the gauge clock domain.
`timescale 1ns/1ps
`default_nettype none
module gauge_alert_mux #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire gauge_misc_pkg::alert_src_e sel,
	input wire logic [W-1:0] reported_charge,
	input wire logic [W-1:0] average_charge,
	input wire logic [W-1:0] mixed_charge,
	input wire logic [W-1:0] voltage_charge,
	output logic [W-1:0] alert_charge
);
	logic [W-1:0] alert_reg;
	logic [W-1:0] alert_next;
	always_comb begin
		unique case (sel)
			gauge_misc_pkg::alert_reported: alert_next = reported_charge;
			gauge_misc_pkg::alert_average: alert_next = average_charge;
			gauge_misc_pkg::alert_mixed: alert_next = mixed_charge;
			gauge_misc_pkg::alert_voltage: alert_next = voltage_charge;
		endcase
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alert_reg <= '0;
		end else begin
			alert_reg <= alert_next;
		end
	end
	assign alert_charge = alert_reg;
	chk_alert_select: assert property (@(posedge clk) disable iff (sys_rst)
		sel == gauge_misc_pkg::alert_voltage
		|=> alert_charge == $past(voltage_charge))
		else $error("Alert source does not follow selection.");
endmodule : gauge_alert_mux
`default_nettype wire

// file: hw/gauge_misc_config_register.sv
// Miscellaneous configuration register of the fuel gauge and its decode.
// Assumes a serial port front end giving single-cycle word reads and writes.
// Contract
// - Charge estimate rate limit is (field plus one) times 8 percent per hour.
// - The rate-limit field resets to 3, a limit of 32 percent per hour.
// - With insertion reset set, each detected battery insertion resets the gauge.
// - The insertion-reset bit is 1 after power-up.
// - Writing the re-initialise bit restarts the gauge initialisation.
// - The mixing field sets servo strength once the final mixing state is reached.
// - A zero mixing field disables servo mixing, keeping time-constant mixing.
// - With auto-revert set, learning select clears to 0 on reaching stage 7.
// - The pull-up select bit chooses the lower-voltage thermistor pull-up.
// - The external-voltage bit stops the device's own cell voltage measurement.
// - The alert source field picks reported, average, mixed or voltage charge.
`timescale 1ns/1ps
`default_nettype none
`include "gauge_misc_cfg.svh"
module gauge_misc_config_register #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	input wire logic update_tick,
	input wire logic insertion_detected,
	input wire logic final_mix_reached,
	input wire logic [2:0] capacity_learn_stage,
	input wire logic [1:0] capacity_learn_select_in,
	input wire logic [W-1:0] reported_charge,
	input wire logic [W-1:0] average_charge,
	input wire logic [W-1:0] mixed_charge,
	input wire logic [W-1:0] voltage_charge,
	output logic [7:0] rate_limit_pct_hr,
	output logic gauge_reset,
	output logic gauge_reinit,
	output logic [4:0] servo_mix_strength,
	output gauge_misc_pkg::mix_mode_e mix_mode,
	output logic learn_clear,
	output logic pullup_low_select,
	output logic volt_meas_enable,
	output logic [W-1:0] alert_charge
);
	localparam logic [15:0] CFG_RESET = `MISC_CFG_RESET;
	localparam logic [7:0] RATE_RESET = 8'((
		{4'h0, CFG_RESET[`RATE_LIMIT_HI:`RATE_LIMIT_LO]} + 8'h01)
		* `RATE_STEP_PCT_HR);
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [15:0] act_reg;
	logic [15:0] act_next;
	logic reinit_reg;
	logic reinit_next;
	logic reset_reg;
	logic reset_next;
	logic clear_reg;
	logic clear_next;
	logic [7:0] rate_reg;
	logic [7:0] rate_next;
	logic pullup_reg;
	logic pullup_next;
	logic meas_reg;
	logic meas_next;
	gauge_misc_pkg::mix_mode_e mode_reg;
	gauge_misc_pkg::mix_mode_e mode_next;
	logic hit_wr;
	assign hit_wr = reg_wr && (reg_addr == `MISC_CFG_ADDR);
	always_comb begin
		cfg_next = cfg_reg;
		reinit_next = 1'b0;
		if (hit_wr) begin
			cfg_next = reg_wdata;
		end
		if (update_tick && cfg_reg[`REINIT_BIT]) begin
			reinit_next = 1'b1;
			cfg_next[`REINIT_BIT] = 1'b0;
		end
		if (hit_wr && reg_wdata[`REINIT_BIT]) begin
			cfg_next[`REINIT_BIT] = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_reg <= CFG_RESET;
			reinit_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			reinit_reg <= reinit_next;
		end
	end
	always_comb begin
		act_next = update_tick ? cfg_reg : act_reg;
		rate_next = 8'(({4'h0, act_next[`RATE_LIMIT_HI:`RATE_LIMIT_LO]}
			+ 8'h01) * `RATE_STEP_PCT_HR);
		pullup_next = act_next[`PULLUP_LOW_BIT];
		meas_next = ~act_next[`EXT_VOLT_BIT];
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			act_reg <= CFG_RESET;
			rate_reg <= RATE_RESET;
			pullup_reg <= CFG_RESET[`PULLUP_LOW_BIT];
			meas_reg <= ~CFG_RESET[`EXT_VOLT_BIT];
		end else begin
			act_reg <= act_next;
			rate_reg <= rate_next;
			pullup_reg <= pullup_next;
			meas_reg <= meas_next;
		end
	end
	always_comb begin
		reset_next = insertion_detected && act_reg[`INSERT_RESET_BIT];
		clear_next = act_reg[`AUTO_REVERT_BIT] && update_tick
			&& capacity_learn_stage == `LEARN_STAGE_REVERT
			&& capacity_learn_select_in != 2'h0;
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reset_reg <= 1'b0;
			clear_reg <= 1'b0;
		end else begin
			reset_reg <= reset_next;
			clear_reg <= clear_next;
		end
	end
	always_comb begin
		if (act_reg[`MIX_HI:`MIX_LO] == 5'h00) begin
			mode_next = gauge_misc_pkg::mix_tc;
		end else if (final_mix_reached) begin
			mode_next = gauge_misc_pkg::mix_servo;
		end else begin
			mode_next = gauge_misc_pkg::mix_tc;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mode_reg <= gauge_misc_pkg::mix_tc;
		end else begin
			mode_reg <= mode_next;
		end
	end
	assign reg_rdata = (reg_addr == `MISC_CFG_ADDR) ? cfg_reg : 16'h0000;
	assign rate_limit_pct_hr = rate_reg;
	assign gauge_reset = reset_reg;
	assign gauge_reinit = reinit_reg;
	assign servo_mix_strength = act_reg[`MIX_HI:`MIX_LO];
	assign mix_mode = mode_reg;
	assign learn_clear = clear_reg;
	assign pullup_low_select = pullup_reg;
	assign volt_meas_enable = meas_reg;
	gauge_alert_mux #(.W(W)) u_alert (
		.clk(clk),
		.sys_rst(sys_rst),
		.sel(gauge_misc_pkg::alert_src_e'(act_reg[`ALERT_SRC_HI:`ALERT_SRC_LO])),
		.reported_charge(reported_charge),
		.average_charge(average_charge),
		.mixed_charge(mixed_charge),
		.voltage_charge(voltage_charge),
		.alert_charge(alert_charge)
	);
	sequence s_reinit_req;
		hit_wr && reg_wdata[`REINIT_BIT];
	endsequence
	sequence s_reinit_issue;
		update_tick && cfg_reg[`REINIT_BIT];
	endsequence
	chk_reset_default: assert property (@(posedge clk)
		$fell(sys_rst) |-> cfg_reg[`INSERT_RESET_BIT]
		&& cfg_reg[`RATE_LIMIT_HI:`RATE_LIMIT_LO] == `RATE_LIMIT_RESET
		&& cfg_reg[`MIX_HI:`MIX_LO] == `MIX_RESET)
		else $error("Reset value wrong.");
	chk_rate_limit: assert property (@(posedge clk) disable iff (sys_rst)
		update_tick |=> rate_limit_pct_hr
		== 8'(({4'h0, $past(cfg_reg[15:12])} + 8'h01) << 3))
		else $error("Rate limit wrong.");
	chk_insert_reset: assert property (@(posedge clk) disable iff (sys_rst)
		insertion_detected && act_reg[11] |=> gauge_reset)
		else $error("Insertion reset missing.");
	chk_reset_cause: assert property (@(posedge clk) disable iff (sys_rst)
		gauge_reset |-> $past(insertion_detected)
		&& $past(act_reg[`INSERT_RESET_BIT]))
		else $error("Gauge reset without insertion.");
	chk_reinit_run: assert property (@(posedge clk) disable iff (sys_rst)
		s_reinit_req ##1 update_tick |=> gauge_reinit)
		else $error("Reinit not issued.");
	chk_reinit_keep: assert property (@(posedge clk) disable iff (sys_rst)
		s_reinit_req |=> cfg_reg[`REINIT_BIT])
		else $error("Reinit request lost.");
	chk_reinit_clear: assert property (@(posedge clk) disable iff (sys_rst)
		s_reinit_issue ##0 !(hit_wr && reg_wdata[`REINIT_BIT])
		|=> !cfg_reg[`REINIT_BIT])
		else $error("Reinit request not cleared.");
	chk_reinit_once: assert property (@(posedge clk) disable iff (sys_rst)
		gauge_reinit && !$past(hit_wr && reg_wdata[`REINIT_BIT])
		|=> !gauge_reinit)
		else $error("Reinit stuck.");
	chk_mix_off: assert property (@(posedge clk) disable iff (sys_rst)
		act_reg[9:5] == 5'h00 |=> mix_mode != gauge_misc_pkg::mix_servo)
		else $error("Servo mixing while disabled.");
	chk_mix_servo: assert property (@(posedge clk) disable iff (sys_rst)
		act_reg[9:5] != 5'h00 && final_mix_reached
		|=> mix_mode == gauge_misc_pkg::mix_servo)
		else $error("Servo mixing not entered.");
	chk_mix_strength: assert property (@(posedge clk) disable iff (sys_rst)
		update_tick
		|=> servo_mix_strength == $past(cfg_reg[`MIX_HI:`MIX_LO]))
		else $error("Mixing strength not applied.");
	chk_learn_revert: assert property (@(posedge clk) disable iff (sys_rst)
		learn_clear |-> $past(capacity_learn_stage) == 3'h7
		&& $past(act_reg[4]))
		else $error("Learn clear without cause.");
	chk_volt_meas: assert property (@(posedge clk) disable iff (sys_rst)
		update_tick
		|=> volt_meas_enable == !$past(cfg_reg[`EXT_VOLT_BIT]))
		else $error("Measurement control wrong.");
	chk_pullup_sel: assert property (@(posedge clk) disable iff (sys_rst)
		update_tick
		|=> pullup_low_select == $past(cfg_reg[`PULLUP_LOW_BIT]))
		else $error("Pull-up select not applied.");
	chk_apply_tick: assert property (@(posedge clk) disable iff (sys_rst)
		!update_tick |=> $stable(act_reg))
		else $error("Settings changed between updates.");
	chk_write_store: assert property (@(posedge clk) disable iff (sys_rst)
		hit_wr |=> cfg_reg == $past(reg_wdata))
		else $error("Written word not stored.");
endmodule : gauge_misc_config_register
`default_nettype wire

// file: tb/tb_gauge_misc_config_register.sv
// Self-checking bench for the gauge miscellaneous configuration register.
// Assumes the design holds its own assertions; drives all ports directly.
`timescale 1ns/1ps
`default_nettype none
module tb_gauge_misc_config_register;
	logic clk = 1'b0;
	logic sys_rst, reg_wr, update_tick, insertion_detected, final_mix_reached;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic [2:0] stage;
	logic [1:0] sel_in;
	logic [15:0] rc, ac, mc, vc, alert_charge;
	logic [7:0] rate_limit_pct_hr;
	logic gauge_reset, gauge_reinit, learn_clear, pullup_low_select;
	logic volt_meas_enable;
	logic [4:0] servo_mix_strength;
	gauge_misc_pkg::mix_mode_e mix_mode;
	integer seed, error_cnt = 0, cmp_count = 0, i;
	always #2.5 clk = ~clk;
	gauge_misc_config_register #(.W(16)) gauge_misc_config_register_i (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .update_tick(update_tick),
		.insertion_detected(insertion_detected),
		.final_mix_reached(final_mix_reached), .capacity_learn_stage(stage),
		.capacity_learn_select_in(sel_in), .reported_charge(rc),
		.average_charge(ac), .mixed_charge(mc), .voltage_charge(vc),
		.rate_limit_pct_hr(rate_limit_pct_hr), .gauge_reset(gauge_reset),
		.gauge_reinit(gauge_reinit), .servo_mix_strength(servo_mix_strength),
		.mix_mode(mix_mode), .learn_clear(learn_clear),
		.pullup_low_select(pullup_low_select),
		.volt_meas_enable(volt_meas_enable), .alert_charge(alert_charge));
	function automatic logic [15:0] exp_alert(input logic [1:0] s);
		case (s)
			2'h0: exp_alert = rc;
			2'h1: exp_alert = ac;
			2'h2: exp_alert = mc;
			default: exp_alert = vc;
		endcase
	endfunction : exp_alert
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk) begin
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= v;
		end
		@(posedge clk) reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic tick;
		@(posedge clk) update_tick <= 1'b1;
		@(posedge clk) update_tick <= 1'b0;
		#1;
	endtask : tick
	task automatic test_done;
		$display("checks %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	initial begin
		seed = 88863;
		{sys_rst, reg_wr, update_tick, insertion_detected} = 4'h8;
		{final_mix_reached, stage, sel_in, reg_wdata} = 0;
		{rc, ac, mc, vc} = 0;
		reg_addr = 8'h2b;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk) #1;
		chk(reg_rdata === 16'h3860, "reset word");
		chk(rate_limit_pct_hr === 8'h20, "reset rate");
		chk(mix_mode === gauge_misc_pkg::mix_tc, "reset mix");
		$display("test reset done");
		wr(8'h2b, 16'h3c60);
		tick();
		chk(gauge_reinit === 1'b1, "reinit pulse");
		@(posedge clk) #1;
		chk(gauge_reinit === 1'b0 && reg_rdata[10] === 1'b0, "reinit end");
		wr(8'h2c, 16'hffff);
		chk(reg_rdata === 16'h0000, "unmapped read");
		@(posedge clk) reg_addr <= 8'h2b;
		@(posedge clk) #1;
		chk(reg_rdata === 16'h3860, "unmapped write");
		$display("test reinit and unmapped done");
		for (i = 0; i < 40; i++) begin
			d = (i == 0) ? 16'hf81f : (i == 1) ? 16'h0000 : $random(seed);
			d[10] = 1'b0;
			@(posedge clk) begin
				rc <= $random(seed);
				ac <= $random(seed);
				mc <= $random(seed);
				vc <= $random(seed);
				final_mix_reached <= $random(seed);
				stage <= 3'h0;
			end
			wr(8'h2b, d);
			chk(reg_rdata === d, "readback");
			tick();
			repeat (2) @(posedge clk);
			#1;
			chk(rate_limit_pct_hr === ({4'h0, d[15:12]} + 8'h01) << 3, "rate");
			chk(servo_mix_strength === d[9:5], "mix strength");
			chk(mix_mode === ((final_mix_reached && d[9:5] != 5'h00) ?
				gauge_misc_pkg::mix_servo : gauge_misc_pkg::mix_tc), "mode");
			chk(pullup_low_select === d[3], "pullup");
			chk(volt_meas_enable === ~d[2], "volt meas");
			chk(alert_charge === exp_alert(d[1:0]), "alert src");
			@(posedge clk) insertion_detected <= 1'b1;
			@(posedge clk) insertion_detected <= 1'b0;
			#1;
			chk(gauge_reset === d[11], "insert reset");
			@(posedge clk) begin
				stage <= ($random(seed) & 1) ? 3'h7 : 3'($random(seed));
				sel_in <= $random(seed);
			end
			tick();
			chk(learn_clear === (stage == 3'h7 && d[4] && sel_in != 2'h0),
				"learn clear");
		end
		$display("test random settings done");
		test_done();
	end
endmodule : tb_gauge_misc_config_register
`default_nettype wire
